// ===== logic/converter_readout.sv
`timescale 1ns/1ps
module converter_readout
  import mode0_pkg::*;
(
  // Conversion timing domain
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to the host
  serial_link_if.dev link,
  // Converter core side
  input wire logic [RESULT_BITS-1:0] sample_value,
  output logic conv_busy,
  output logic clocked_mode
);

  // ---------------------------------------------------------------
  // State of the conversion domain
  // ---------------------------------------------------------------
  typedef struct packed {
    dev_state_e state;
    logic [1:0] start_sync;
    logic start_prev;
    logic [1:0] sclk_sync;
    logic sclk_prev;
    logic [TIMER_W-1:0] timer;
    logic [RESULT_BITS-1:0] held;
    logic [WORD_BITS-1:0] word;
    logic cnt_clr;
    logic clocked_mode;
  } core_s;

  core_s core_ff;
  core_s nxt_core;

  // ---------------------------------------------------------------
  // State of the link domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] bit_cnt;
    logic [WORD_BITS-1:0] shadow;
    logic dout;
  } link_s;

  link_s link_ff;
  link_s nxt_link;

  logic start_fall;
  logic sclk_edge;
  logic link_rst_n;
  logic clk_in_conv;
  logic conv_done;
  logic word_done;
  logic [WORD_BITS-1:0] out_word;

  // ---------------------------------------------------------------
  // Edge detection on the synchronised pins
  // ---------------------------------------------------------------
  // Reports a falling edge, or any edge when fall_only is low.
  function automatic logic pin_edge(input logic prev,
                                    input logic cur,
                                    input logic fall_only);
    logic seen;
    seen = prev ^ cur;
    if (fall_only)
    begin
      seen = prev & ~cur;
    end
    return seen;
  endfunction

  // ---------------------------------------------------------------
  // Conversion control
  // ---------------------------------------------------------------
  // Pins are read only after the second synchroniser stage.
  assign start_fall = pin_edge(core_ff.start_prev, core_ff.start_sync[1], 1'b1);
  assign sclk_edge = pin_edge(core_ff.sclk_prev, core_ff.sclk_sync[1], 1'b0);
  // A clock edge while start is low ends the conversion unfinished.
  assign clk_in_conv = sclk_edge & ~core_ff.start_sync[1];
  assign conv_done = (core_ff.timer == TIMER_W'(CONV_CYC - 1));

  always_comb
  begin
    nxt_core = core_ff;
    nxt_core.start_sync = {core_ff.start_sync[0], link.conversion_start_n};
    nxt_core.sclk_sync = {core_ff.sclk_sync[0], link.sclk};
    nxt_core.start_prev = core_ff.start_sync[1];
    nxt_core.sclk_prev = core_ff.sclk_sync[1];
    case (core_ff.state)
      DEV_IDLE:
      begin
        if (start_fall)
        begin
          nxt_core.held = sample_value;
          nxt_core.timer = '0;
          nxt_core.clocked_mode = 1'b0;
          // The bit counter is only resynchronised while the clock rests low.
          nxt_core.cnt_clr = ~core_ff.sclk_sync[1];
          nxt_core.state = DEV_CONVERT;
        end
      end
      DEV_CONVERT:
      begin
        if (clk_in_conv)
        begin
          nxt_core.clocked_mode = 1'b1;
          nxt_core.cnt_clr = 1'b0;
          nxt_core.state = DEV_IDLE;
        end
        else if (conv_done)
        begin
          // New result enters the output word behind the leading zeros.
          nxt_core.word = {{LEAD_ZEROS{1'b0}}, core_ff.held};
          nxt_core.cnt_clr = 1'b0;
          nxt_core.state = DEV_IDLE;
        end
        else
        begin
          nxt_core.timer = core_ff.timer + TIMER_W'(1);
        end
      end
      default:
      begin
        nxt_core.state = DEV_IDLE;
        nxt_core.cnt_clr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Start synchroniser rests high so its release shows no false edge.
      core_ff <= '{state: DEV_IDLE, start_sync: PIN_HIGH_SYNC_RST, start_prev: 1'b1,
                   default: '0};
    end
    else
    begin
      core_ff <= nxt_core;
    end
  end

  // ---------------------------------------------------------------
  // Serial shifter on the host clock
  // ---------------------------------------------------------------
  // The counter is held cleared from the start edge until the result is
  // loaded; the host keeps the clock still over that span, so the word
  // register is stable whenever this domain reads it.
  assign link_rst_n = rst_n & ~core_ff.cnt_clr;
  assign word_done = (int'(link_ff.bit_cnt) >= WORD_BITS);
  // The first rising edge takes its own copy of the word, so a start given
  // with the clock high cannot change a word that is half shifted out.
  assign out_word = (link_ff.bit_cnt == BIT_CNT_RST) ? core_ff.word : link_ff.shadow;

  always_comb
  begin
    nxt_link = link_ff;
    if (link_ff.bit_cnt == BIT_CNT_RST)
    begin
      nxt_link.shadow = core_ff.word;
    end
    if (!word_done)
    begin
      nxt_link.bit_cnt = link_ff.bit_cnt + CNT_W'(1);
      // The bit at the current count goes out, so the first rising edge
      // keeps the leading zero that was already valid before it.
      nxt_link.dout = word_bit(out_word, link_ff.bit_cnt);
    end
    else
    begin
      // Counter stays exhausted until a start given with the clock low clears it.
      nxt_link.dout = DOUT_RST;
    end
  end

  always_ff @(posedge link.sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      // The first bit is a leading zero, so it is valid straight from reset.
      link_ff <= '{bit_cnt: BIT_CNT_RST, shadow: '0, dout: DOUT_RST};
    end
    else
    begin
      link_ff <= nxt_link;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign conv_busy = (core_ff.state == DEV_CONVERT);
  assign clocked_mode = core_ff.clocked_mode;
  assign link.serial_data_out = link_ff.dout;

endmodule

// ===== logic/mode0_pkg.sv
package mode0_pkg;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int CNT_W = 5;
  localparam int TIMER_W = 10;

  // ---------------------------------------------------------------
  // Timing, core clock at 200 MHz
  // ---------------------------------------------------------------
  localparam real CORE_CLK_NS = 5.0;
  localparam real READ_DELAY_US = 3.3;
  localparam int READ_DELAY_CYC = int'($ceil(READ_DELAY_US * 1000.0 / CORE_CLK_NS));
  localparam int CONV_MARGIN_CYC = 8;
  localparam int CONV_CYC = READ_DELAY_CYC - CONV_MARGIN_CYC;
  localparam real SCLK_MAX_MHZ = 15.0;
  localparam int SCLK_HALF_CYC = int'($ceil(1000.0 / SCLK_MAX_MHZ / 2.0 / CORE_CLK_NS));
  localparam real START_LOW_NS = 40.0;
  localparam int START_LOW_CYC = int'($ceil(START_LOW_NS / CORE_CLK_NS));

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [1:0] PIN_HIGH_SYNC_RST = 2'h3;
  localparam logic DOUT_RST = 1'b0;
  localparam logic [CNT_W-1:0] BIT_CNT_RST = 5'h00;

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_CONVERT = 2'b10
  } dev_state_e;

  typedef enum logic [4:0] {
    HOST_IDLE = 5'b00001,
    HOST_WAIT = 5'b00010,
    HOST_CLK_HI = 5'b00100,
    HOST_CLK_LO = 5'b01000,
    HOST_DONE = 5'b10000
  } host_state_e;

  // Bit of the read word presented after idx+1 rising edges, zero once exhausted.
  function automatic logic word_bit(input logic [WORD_BITS-1:0] word,
                                    input logic [CNT_W-1:0] idx);
    logic b;
    b = 1'b0;
    if (int'(idx) < WORD_BITS)
    begin
      b = word[WORD_BITS-1-int'(idx)];
    end
    return b;
  endfunction

endpackage

// ===== logic/serial_link_if.sv
`timescale 1ns/1ps
interface serial_link_if;
  // Serial clock from the host, gated by its select bit.
  logic sclk;
  // Active-low conversion start from the host.
  logic conversion_start_n;
  // Read data from the converter.
  logic serial_data_out;

  modport dev (
    input sclk,
    input conversion_start_n,
    output serial_data_out
  );

  modport host (
    output sclk,
    output conversion_start_n,
    input serial_data_out
  );
endinterface

// ===== logic/host_reader.sv
`timescale 1ns/1ps
module host_reader
  import mode0_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to the converter
  serial_link_if.host link,
  // User side
  input wire logic read_req,
  input wire logic device_select,
  output logic read_busy,
  output logic [RESULT_BITS-1:0] result,
  output logic result_valid
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    host_state_e state;
    logic [TIMER_W-1:0] timer;
    logic [CNT_W-1:0] bit_cnt;
    logic [WORD_BITS-1:0] shreg;
    logic [1:0] din_sync;
    logic sclk;
    logic start_n;
    logic sel;
    logic [RESULT_BITS-1:0] result;
    logic result_valid;
  } host_s;

  host_s host_ff;
  host_s nxt_host;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_host = host_ff;
    nxt_host.din_sync = {host_ff.din_sync[0], link.serial_data_out};
    nxt_host.sel = device_select;
    nxt_host.result_valid = 1'b0;
    case (host_ff.state)
      HOST_IDLE:
      begin
        nxt_host.sclk = 1'b0;
        if (read_req)
        begin
          nxt_host.start_n = 1'b0;
          nxt_host.timer = '0;
          nxt_host.bit_cnt = '0;
          nxt_host.state = HOST_WAIT;
        end
      end
      HOST_WAIT:
      begin
        // Clock stays low through the conversion; no busy pin exists.
        nxt_host.timer = host_ff.timer + TIMER_W'(1);
        if (host_ff.timer == TIMER_W'(START_LOW_CYC - 1))
        begin
          nxt_host.start_n = 1'b1;
        end
        if (host_ff.timer == TIMER_W'(READ_DELAY_CYC - 1))
        begin
          nxt_host.timer = '0;
          nxt_host.sclk = 1'b1;
          nxt_host.state = HOST_CLK_HI;
        end
      end
      HOST_CLK_HI:
      begin
        nxt_host.timer = host_ff.timer + TIMER_W'(1);
        if (host_ff.timer == TIMER_W'(SCLK_HALF_CYC - 1))
        begin
          nxt_host.timer = '0;
          nxt_host.sclk = 1'b0;
          // Capture on the falling edge, most significant bit first.
          nxt_host.shreg = {host_ff.shreg[WORD_BITS-2:0], host_ff.din_sync[1]};
          nxt_host.bit_cnt = host_ff.bit_cnt + CNT_W'(1);
          nxt_host.state = HOST_CLK_LO;
        end
      end
      HOST_CLK_LO:
      begin
        nxt_host.timer = host_ff.timer + TIMER_W'(1);
        if (host_ff.timer == TIMER_W'(SCLK_HALF_CYC - 1))
        begin
          nxt_host.timer = '0;
          if (int'(host_ff.bit_cnt) == WORD_BITS)
          begin
            nxt_host.state = HOST_DONE;
          end
          else
          begin
            nxt_host.sclk = 1'b1;
            nxt_host.state = HOST_CLK_HI;
          end
        end
      end
      HOST_DONE:
      begin
        // Leading zeros are dropped; the result sits in the low bits.
        nxt_host.result = host_ff.shreg[RESULT_BITS-1:0];
        nxt_host.result_valid = 1'b1;
        nxt_host.state = HOST_IDLE;
      end
      default:
      begin
        nxt_host.state = HOST_IDLE;
        nxt_host.sclk = 1'b0;
        nxt_host.start_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_ff <= '{state: HOST_IDLE, start_n: 1'b1, default: '0};
    end
    else
    begin
      host_ff <= nxt_host;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Select bit gates the clock so a deselected converter sees no edges.
  assign link.sclk = host_ff.sclk & host_ff.sel;
  assign link.conversion_start_n = host_ff.start_n;
  assign read_busy = (host_ff.state != HOST_IDLE);
  assign result = host_ff.result;
  assign result_valid = host_ff.result_valid;

endmodule

// ===== testbench/readout_asserts.sv
`timescale 1ns/1ps
module readout_asserts
  import mode0_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link
  input wire logic sclk,
  input wire logic conversion_start_n,
  input wire logic serial_data_out
);
  // ---------------------------------------------------------------
  // Rising edges and cycles since the last start
  // ---------------------------------------------------------------
  int cnt_ff;
  int tim_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 0;
      tim_ff <= 0;
    end
    else
    begin
      tim_ff <= $fell(conversion_start_n) ? 0 : tim_ff + 1;
      if ($fell(conversion_start_n) && !sclk)
        cnt_ff <= 0;
      else if ($rose(sclk))
        cnt_ff <= cnt_ff + 1;
    end
  end

  chk_data_steady: assert property (!$rose(sclk) && conversion_start_n |-> $stable(serial_data_out))
    else $error("data moved without a rising clock");
  chk_lead_zeros: assert property (conversion_start_n && !$rose(sclk) && cnt_ff < 4 |-> !serial_data_out)
    else $error("leading bit not zero");
  chk_after_last: assert property ($rose(sclk) && cnt_ff >= 16 |-> !serial_data_out)
    else $error("data after last bit not zero");
  chk_pulse_count: assert property (cnt_ff <= WORD_BITS)
    else $error("more than sixteen pulses");
  chk_read_delay: assert property ($rose(sclk) |-> tim_ff + 1 >= READ_DELAY_CYC)
    else $error("clock before read delay");
  chk_start_clk_low: assert property ($fell(conversion_start_n) |-> !sclk)
    else $error("clock high at start");
  chk_half_period: assert property ($fell(sclk) && cnt_ff < 16 |-> !sclk [*7] ##1 sclk)
    else $error("low phase length wrong");
  chk_rest_low: assert property (cnt_ff == WORD_BITS && !sclk |=> !sclk)
    else $error("clock rose after the word");
  chk_read_done: assert property ($rose(sclk) && cnt_ff == 0 |-> ##[1:300] cnt_ff == 16)
    else $error("word not read in time");

  cover property ($fell(conversion_start_n));
  cover property ($rose(sclk) && cnt_ff == 15);
  cover property (cnt_ff == WORD_BITS && $fell(sclk));
endmodule

// ===== testbench/mode0_serial_readout_tb_top.sv
`timescale 1ns/1ps
module mode0_serial_readout_tb_top
  import mode0_pkg::*;
;
  logic core_clk;
  logic rst_n;
  logic read_req;
  logic device_select;
  logic [RESULT_BITS-1:0] sample_value;
  logic [RESULT_BITS-1:0] result;
  logic result_valid, conv_busy, clocked_mode, busy2, mode2;
  logic [15:0] sh;
  int np;
  int n_errors;
  int checks_done;

  serial_link_if lk ();
  serial_link_if lk2 ();

  converter_readout converter_readout_i (.core_clk(core_clk), .rst_n(rst_n), .link(lk.dev),
    .sample_value(sample_value), .conv_busy(conv_busy), .clocked_mode(clocked_mode));
  host_reader host_reader_i (.core_clk(core_clk), .rst_n(rst_n), .link(lk.host),
    .read_req(read_req), .device_select(device_select), .read_busy(), .result(result),
    .result_valid(result_valid));
  converter_readout converter_readout_i2 (.core_clk(core_clk), .rst_n(rst_n), .link(lk2.dev),
    .sample_value(sample_value), .conv_busy(busy2), .clocked_mode(mode2));
  readout_asserts readout_asserts_i (.core_clk(core_clk), .rst_n(rst_n), .sclk(lk.sclk),
    .conversion_start_n(lk.conversion_start_n), .serial_data_out(lk.serial_data_out));

  // ---------------------------------------------------------------
  // Clock, wire monitor and helpers
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(negedge lk.sclk)
  begin
    sh = {sh[14:0], lk.serial_data_out};
    np++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse2();
    #1;
    lk2.sclk = 1'b1;
    #7.5;
    lk2.sclk = 1'b0;
    #6.5;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_read(input logic [11:0] v, input logic sel);
    int i;
    @(negedge core_clk);
    sample_value = v;
    device_select = sel;
    np = 0;
    read_req = 1'b1;
    @(negedge core_clk);
    read_req = 1'b0;
    for (i = 0; i < 1200 && result_valid !== 1'b1; i++)
      @(negedge core_clk);
    check({4'h0, result}, {4'h0, sel ? v : 12'h000});
    check(16'(np), sel ? 16'h0010 : 16'h0000);
    if (sel)
      check(sh, {4'h0, v});
    check({14'h0, conv_busy, clocked_mode}, 16'h0000);
    $display("read %h select %b done", v, sel);
  endtask

  task automatic t_abandon();
    @(negedge core_clk);
    lk2.conversion_start_n = 1'b0;
    repeat (40) @(negedge core_clk);
    pulse2();
    repeat (4) @(negedge core_clk);
    check({14'h0, busy2, mode2}, 16'h0001);
    lk2.conversion_start_n = 1'b1;
    $display("abandon done");
  endtask

  task automatic t_direct(input logic [11:0] v);
    logic [15:0] w;
    int i;
    w = {4'h0, v};
    @(negedge core_clk);
    sample_value = v;
    lk2.conversion_start_n = 1'b0;
    repeat (8) @(negedge core_clk);
    lk2.conversion_start_n = 1'b1;
    repeat (READ_DELAY_CYC) @(negedge core_clk);
    check({14'h0, busy2, mode2}, 16'h0000);
    check({15'h0, lk2.serial_data_out}, {15'h0, w[15]});
    for (i = 0; i < 17; i++)
    begin
      #1;
      lk2.sclk = 1'b1;
      #7.5;
      check({15'h0, lk2.serial_data_out}, {15'h0, i < 16 ? w[15-i] : 1'b0});
      lk2.sclk = 1'b0;
      #6.5;
    end
    check({15'h0, lk2.serial_data_out}, 16'h0000);
    $display("direct read %h done", v);
  endtask

  initial
  begin
    rst_n = 1'b0;
    read_req = 1'b0;
    device_select = 1'b0;
    sample_value = 12'h000;
    lk2.sclk = 1'b0;
    lk2.conversion_start_n = 1'b1;
    n_errors = 0;
    checks_done = 0;
    np = 0;
    sh = 16'h0000;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_read(12'hABC, 1'b1);
    t_read(12'hFFF, 1'b1);
    t_read(12'h000, 1'b1);
    t_read(12'h5A5, 1'b0);
    t_read(12'h123, 1'b1);
    t_abandon();
    t_direct(12'h9C6);
    finish_test();
  end

  initial
  begin
    #100000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
